/* hw/sadc_pkg.sv */
// Purpose: shared constants for the serial sampling converter control block
// Assumes: aclk at 100 MHz, AXI4-Lite register access with 32-bit data
// Notes: register offsets are byte addresses
package sadc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RESULT_BITS = 14;
    localparam int unsigned WORD_BITS = 16;
    localparam logic [4:0] CONV_CYCLES = 5'h10;
    // conv_clock_input held high this long means internal oscillator selected
    localparam int unsigned EXT_IDLE_NS = 20000;
    localparam int unsigned EXT_IDLE_CYCLES = EXT_IDLE_NS / CLK_PERIOD_NS;
    localparam logic [7:0] OSC_HALF_RESET = 8'h06;

    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam logic [3:0] REG_COUNT = 4'hC;

    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_NAP = 1;
    localparam int unsigned ST_SLEEP = 2;
    localparam int unsigned ST_EXT = 3;
    localparam int unsigned ST_BIPOLAR = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SADC_IDLE = 4'h1,
        SADC_CONV = 4'h2,
        SADC_LOAD = 4'h4,
        SADC_DOWN = 4'h8
    } sadc_state_t;
endpackage

/* hw/sadc_sync.sv */
// Purpose: two-flop synchroniser bank with rise and fall detection
// Assumes: inputs are asynchronous pins
// Notes: edge detection looks only at the second and third flops
`timescale 1ns/1ns
module sadc_sync #(
    parameter int WIDTH = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    initial begin
        if (WIDTH < 1) begin
            $error("sadc_sync: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } sadc_sync_t;

    sadc_sync_t r;
    sadc_sync_t next_r;

    always_comb begin
        next_r = r;
        if (ce) begin
            next_r.s1 = pin;
            next_r.s2 = r.s1;
            next_r.s3 = r.s2;
        end
    end

    // pins idle high (active-low strobes), so reset to ones avoids false edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.s2;
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule

/* hw/sadc_shift.sv */
// Purpose: output shift register, msb first, zero fill
// Assumes: shift pulse already gated by the output enable
// Notes: load has priority over a shift in the same cycle
`timescale 1ns/1ns
module sadc_shift #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_word,
    input wire logic shift,
    output logic dout
);
    initial begin
        if (WIDTH < 2) begin
            $error("sadc_shift: WIDTH must be at least 2");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] sr;
    } sadc_shift_t;

    sadc_shift_t r;
    sadc_shift_t next_r;

    always_comb begin
        next_r = r;
        if (ce) begin
            if (load) begin
                next_r.sr = load_word;
            end else if (shift) begin
                next_r.sr = {r.sr[WIDTH-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign dout = r.sr[WIDTH-1];
endmodule

/* hw/sadc_top.sv */
// Purpose: conversion control and serial readout of a 14-bit sampling converter
// Assumes: adc_code comes from the analog core on aclk, offset binary
// Notes: the internal conversion clock is aclk-derived; pins are synchronised first
// Behaviour
// - power_down_n low puts the block in power-down; high runs normally
// - in power-down, read_en_n low means nap, high means sleep
// - falling edge on convert_start_n starts a conversion
// - start edges during a conversion are ignored until it ends
// - busy_n stays low for the whole conversion
// - shift register loads the result first, then busy_n rises
// - old result stays in the shift register until the next load
// - read_en_n high ignores shift clock and releases dout
// - unipolar gives straight binary, bipolar gives two's complement
// - conv_clock_input held high selects internal clock, 16 cycles
// - end of conversion gates external clock after 16 cycles
// - with read_en_n low, 16 cycles copied to conv_clock_output, then low
// - 16-bit shift register clocked by shift clock drives dout
// - sixteen shift clocks give 14 result bits msb first, two zeros
// - bits change on shift clock falling edges, msb valid from start
// - extra shift clocks keep shifting out zeros
`timescale 1ns/1ns
module sadc_top
    import sadc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic power_down_n,
    input wire logic convert_start_n,
    input wire logic conv_clock_input,
    input wire logic shift_clock,
    input wire logic read_en_n,
    input wire logic negative_supply,
    input wire logic [sadc_pkg::RESULT_BITS-1:0] adc_code,
    output logic busy_n,
    output logic conv_clock_output,
    output logic dout,
    output logic dout_oe,
    output logic nap,
    output logic sleep,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sadc_pkg::*;

    localparam int unsigned SYN_POWER_DOWN_N = 0;
    localparam int unsigned SYN_CONV = 1;
    localparam int unsigned SYN_EXT = 2;
    localparam int unsigned SYN_SCLK = 3;
    localparam int unsigned SYN_RD = 4;
    localparam int unsigned SYN_VSS = 5;

    typedef struct packed {
        sadc_state_t state;
        logic [4:0] cyc;
        logic [7:0] div;
        logic cclk;
        logic [RESULT_BITS-1:0] code;
        logic ext_sel;
        logic [11:0] idle_cnt;
        logic [7:0] osc_half;
        logic [WORD_BITS-1:0] result;
        logic [31:0] conv_count;
        logic busy_n;
        logic cout;
        logic dout_oe;
        logic nap;
        logic sleep;
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sadc_top_t;

    sadc_top_t r;
    sadc_top_t next_r;

    logic [5:0] pin_level;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic load;
    logic shift;
    logic [WORD_BITS-1:0] load_word;
    logic shift_dout;

    // shift_clock idles low but the sync flops reset high, so it enters inverted
    // to keep a false fall out of the first cycles after reset
    sadc_sync #(.WIDTH(6)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin({negative_supply, read_en_n, ~shift_clock, conv_clock_input,
              convert_start_n, power_down_n}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // bipolar flips the msb of offset binary into two's complement
    assign load_word = {r.code[RESULT_BITS-1] ^ pin_level[SYN_VSS],
                        r.code[RESULT_BITS-2:0], 2'b00};
    assign load = (r.state == SADC_LOAD);
    // a rise of the inverted copy is a shift clock fall; ignored while read_en_n high
    assign shift = pin_rise[SYN_SCLK] & ~pin_level[SYN_RD];

    sadc_shift #(.WIDTH(WORD_BITS)) u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .load(load),
        .load_word(load_word),
        .shift(shift),
        .dout(shift_dout)
    );

    always_comb begin
        logic cc_rise;
        logic cc_fall;
        logic wr_fire;
        logic [31:0] rd_word;
        cc_rise = 1'b0;
        cc_fall = 1'b0;
        wr_fire = 1'b0;
        rd_word = 32'h0;
        next_r = r;
        if (ce) begin
            // external clock detection: a long high level means internal select
            if (pin_level[SYN_EXT]) begin
                if (r.idle_cnt < 12'(EXT_IDLE_CYCLES)) begin
                    next_r.idle_cnt = r.idle_cnt + 12'h001;
                end else begin
                    next_r.ext_sel = 1'b0;
                end
            end else begin
                next_r.idle_cnt = 12'h000;
                next_r.ext_sel = 1'b1;
            end

            // conversion clock source
            if (r.ext_sel) begin
                cc_rise = pin_rise[SYN_EXT];
                cc_fall = pin_fall[SYN_EXT];
            end else if (r.state == SADC_CONV) begin
                if (r.div == 8'h00) begin
                    next_r.div = r.osc_half;
                    cc_rise = ~r.cclk;
                    cc_fall = r.cclk;
                end else begin
                    next_r.div = r.div - 8'h01;
                end
            end

            unique case (r.state)
                SADC_IDLE: begin
                    next_r.cclk = 1'b0;
                    next_r.cout = 1'b0;
                    next_r.busy_n = 1'b1;
                    if (!pin_level[SYN_POWER_DOWN_N]) begin
                        next_r.state = SADC_DOWN;
                    // busy_n is still low just after a load: a start then is ignored
                    end else if (pin_fall[SYN_CONV] && r.busy_n) begin
                        next_r.state = SADC_CONV;
                        next_r.code = adc_code;
                        next_r.cyc = 5'h00;
                        next_r.div = r.osc_half;
                        next_r.busy_n = 1'b0;
                    end
                end
                SADC_CONV: begin
                    // start edges are simply not looked at here
                    if (!pin_level[SYN_POWER_DOWN_N]) begin
                        next_r.state = SADC_DOWN;
                        next_r.busy_n = 1'b1;
                        next_r.cout = 1'b0;
                        next_r.cclk = 1'b0;
                    end else begin
                        if (cc_rise) begin
                            next_r.cclk = 1'b1;
                            next_r.cout = ~pin_level[SYN_RD];
                        end
                        if (cc_fall && r.cclk) begin
                            next_r.cclk = 1'b0;
                            next_r.cout = 1'b0;
                            next_r.cyc = r.cyc + 5'h01;
                            // extra external cycles are dropped after 16
                            if (r.cyc + 5'h01 == CONV_CYCLES) begin
                                next_r.state = SADC_LOAD;
                            end
                        end
                    end
                end
                SADC_LOAD: begin
                    // shift register loads here; idle raises busy_n one edge later
                    // until then the old word stays put
                    next_r.state = SADC_IDLE;
                    next_r.result = load_word;
                    next_r.conv_count = r.conv_count + 32'h1;
                end
                SADC_DOWN: begin
                    if (pin_level[SYN_POWER_DOWN_N]) begin
                        next_r.state = SADC_IDLE;
                    end
                end
            endcase
            // read_en_n going high cuts a pulse short rather than let it run on
            if (pin_level[SYN_RD]) begin
                next_r.cout = 1'b0;
            end
            next_r.nap = (next_r.state == SADC_DOWN) & ~pin_level[SYN_RD];
            next_r.sleep = (next_r.state == SADC_DOWN) & pin_level[SYN_RD];
            next_r.dout_oe = ~pin_level[SYN_RD];

            // write channel: address and data accepted in either order
            if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
                next_r.aw_got = 1'b1;
                next_r.aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
                next_r.w_got = 1'b1;
                next_r.w_data = s_axi_wdata;
                next_r.w_strb = s_axi_wstrb;
            end
            wr_fire = r.aw_got & r.w_got & ~r.bvalid;
            if (wr_fire) begin
                next_r.aw_got = 1'b0;
                next_r.w_got = 1'b0;
                next_r.bvalid = 1'b1;
                next_r.bresp = RESP_OKAY;
                unique case (r.aw_addr)
                    REG_CONFIG: begin
                        if (r.w_strb[0]) begin
                            next_r.osc_half = r.w_data[7:0];
                        end
                    end
                    REG_STATUS, REG_RESULT, REG_COUNT: begin
                        next_r.bresp = RESP_OKAY;
                    end
                    default: begin
                        next_r.bresp = RESP_SLVERR;
                    end
                endcase
            end
            if (r.bvalid && s_axi_bready) begin
                next_r.bvalid = 1'b0;
            end

            // read channel: arready is high whenever no answer is pending
            if (s_axi_arvalid && !r.rvalid) begin
                next_r.rvalid = 1'b1;
                next_r.rresp = RESP_OKAY;
                unique case (s_axi_araddr)
                    REG_CONFIG: rd_word = {24'h0, r.osc_half};
                    REG_STATUS: begin
                        rd_word[ST_BUSY] = ~r.busy_n;
                        rd_word[ST_NAP] = r.nap;
                        rd_word[ST_SLEEP] = r.sleep;
                        rd_word[ST_EXT] = r.ext_sel;
                        rd_word[ST_BIPOLAR] = pin_level[SYN_VSS];
                    end
                    REG_RESULT: rd_word = {16'h0, r.result};
                    REG_COUNT: rd_word = r.conv_count;
                    default: begin
                        rd_word = 32'h0;
                        next_r.rresp = RESP_SLVERR;
                    end
                endcase
                next_r.rdata = rd_word;
            end else if (r.rvalid && s_axi_rready) begin
                next_r.rvalid = 1'b0;
            end
        end
    end

    // no reset pin on the converter itself; aresetn stands in for power-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.state <= SADC_IDLE;
            r.osc_half <= OSC_HALF_RESET;
            r.busy_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // dout itself is the shift register's own msb flop
    assign dout = shift_dout;
    assign busy_n = r.busy_n;
    assign conv_clock_output = r.cout;
    assign dout_oe = r.dout_oe;
    assign nap = r.nap;
    assign sleep = r.sleep;
    assign s_axi_awready = ~r.aw_got & ~r.bvalid;
    assign s_axi_wready = ~r.w_got & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
endmodule

/* verification/sadc_top_sva.sv */
// Purpose: pin-level assertions for sadc_top
// Assumes: ce held high; code and supply mode stable through a conversion
// Notes: pin synchronisers add about three cycles, hence the margins
`timescale 1ns/1ns
module sadc_top_sva
    import sadc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_down_n,
    input wire logic convert_start_n,
    input wire logic shift_clock,
    input wire logic read_en_n,
    input wire logic negative_supply,
    input wire logic [sadc_pkg::RESULT_BITS-1:0] adc_code,
    input wire logic busy_n,
    input wire logic conv_clock_output,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic nap,
    input wire logic sleep,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    logic [4:0] pulses;
    logic [3:0] since_fall;
    logic co_q, bn_q, sc_q, msb_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        co_q <= conv_clock_output;
        bn_q <= busy_n;
        sc_q <= shift_clock;
        if (bn_q && !busy_n) begin
            msb_q <= adc_code[RESULT_BITS-1];
        end
        if (!aresetn || (busy_n && bn_q)) begin
            pulses <= 5'h00;
        end else if (conv_clock_output && !co_q) begin
            pulses <= pulses + 5'h01;
        end
        // only enabled falls count, so a gated-off shift clock may not move dout
        if (!aresetn || (sc_q && !shift_clock && !read_en_n)) begin
            since_fall <= 4'h0;
        end else if (since_fall != 4'hF) begin
            since_fall <= since_fall + 4'h1;
        end
    end
    sequence s_idle_fall;
        (power_down_n && busy_n)[*6] ##1 $fell(convert_start_n);
    endsequence
    sequence s_done;
        $rose(busy_n) && power_down_n;
    endsequence
    property p_start;
        s_idle_fall |-> ##[1:6] !busy_n;
    endproperty
    property p_pulses;
        s_done ##0 !read_en_n |-> pulses == CONV_CYCLES;
    endproperty
    property p_quiet;
        busy_n && bn_q |-> !conv_clock_output;
    endproperty
    property p_off;
        read_en_n[*6] |-> !dout_oe && !conv_clock_output;
    endproperty
    property p_nap;
        (!power_down_n && !read_en_n)[*6] |-> nap && !sleep;
    endproperty
    property p_sleep;
        (!power_down_n && read_en_n)[*6] |-> sleep && !nap;
    endproperty
    property p_load;
        s_done |-> dout == (msb_q ^ negative_supply);
    endproperty
    property p_shift;
        $changed(dout) && busy_n && bn_q && $past(bn_q) |-> since_fall < 4'h7;
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_start: assert property (p_start)
        else $error("start edge gave no conversion");
    a_pulses: assert property (p_pulses)
        else $error("conversion clock count wrong");
    a_quiet: assert property (p_quiet)
        else $error("clock output active while idle");
    a_off: assert property (p_off)
        else $error("output not released");
    a_nap: assert property (p_nap)
        else $error("nap mode wrong");
    a_sleep: assert property (p_sleep)
        else $error("sleep mode wrong");
    a_load: assert property (p_load)
        else $error("result not loaded before busy end");
    a_shift: assert property (p_shift)
        else $error("data moved without shift clock");
    a_rhold: assert property (p_rhold)
        else $error("read data dropped early");
endmodule
bind sadc_top sadc_top_sva u_sva (.*);

/* verification/sadc_host.sv */
// Purpose: host model starting conversions and reading serial words
// Assumes: shift clock period 125 ns, data taken on rising edges
// Notes: shift clock stands low between frames
`timescale 1ns/1ns
module sadc_host #(
    parameter int NAP_WAKE = 50,
    parameter int SLEEP_WAKE = 3000000
) (
    input wire logic aclk,
    input wire logic busy_n,
    input wire logic dout,
    input wire logic dout_oe,
    output logic convert_start_n,
    output logic shift_clock,
    output logic read_en_n
);
    // a released line reads inverted so it never passes for data
    wire logic line = dout_oe ? dout : ~dout;
    initial begin
        convert_start_n = 1'b1;
        shift_clock = 1'b0;
        read_en_n = 1'b0;
    end
    task automatic start();
        @(posedge aclk);
        convert_start_n <= 1'b0;
        repeat (6) @(posedge aclk);
        convert_start_n <= 1'b1;
    endtask
    task automatic wake(input logic from_sleep);
        repeat (from_sleep ? SLEEP_WAKE : NAP_WAKE) @(posedge aclk);
    endtask
    // called only with busy_n high: no shifting during an internal conversion
    task automatic read_word(input int n, input logic gate, output logic [31:0] w);
        w = 32'h0;
        @(posedge aclk);
        read_en_n <= gate;
        repeat (8) @(posedge aclk);
        // offset by 1 ns so that no shift clock change lands on an aclk edge
        #1;
        for (int i = 0; i < n; i++) begin
            #62 shift_clock = 1'b1;
            w = {w[30:0], line};
            #63 shift_clock = 1'b0;
        end
        #200;
    endtask
endmodule

/* verification/sadc_top_tb.sv */
// Purpose: self-checking bench for sadc_top
// Assumes: ce held high, host model drives the serial link
// Notes: sleep wake wait shortened to keep the run brief
`timescale 1ns/1ns
`define CHK(got, wv) begin checks++; if ((got) !== (wv)) begin num_errors++; \
$display("wrong value at %0t: got %h want %h", $time, got, wv); end end
module sadc_top_tb;
    import sadc_pkg::*;
    typedef struct packed {
        logic [13:0] code;
        logic bip;
        logic [5:0] n;
        logic [15:0] word;
    } sadc_row_t;
    localparam sadc_row_t ROWS [5] = '{'{14'h3FFF, 1'b0, 6'h10, 16'hFFFC},
        '{14'h0001, 1'b0, 6'h0E, 16'h0004}, '{14'h2AAA, 1'b1, 6'h14, 16'h2AA8},
        '{14'h1555, 1'b1, 6'h10, 16'hD554}, '{14'h2000, 1'b0, 6'h10, 16'h8000}};
    logic aclk = 1'b0;
    logic conv_clock_input = 1'b1;
    logic aresetn, ce, power_down_n, negative_supply, ext_run;
    logic [13:0] adc_code;
    logic busy_n, conv_clock_output, dout, dout_oe, nap, sleep;
    logic convert_start_n, shift_clock, read_en_n;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, w, want;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int num_errors = 0;
    int checks = 0;
    sadc_top dut (.*);
    sadc_host #(.SLEEP_WAKE(500)) host (.*);
    always #5 aclk = ~aclk;
    // stands high (internal select) whenever the external clock is off
    always #100 conv_clock_input = ext_run ? ~conv_clock_input : 1'b1;
    task automatic conclude();
        $display("counts: %0d checks, %0d errors", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic guard(input logic fail);
        if (fail) begin
            num_errors++;
            $display("wrong value at %0t: wait ran out", $time);
            conclude();
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 100 && s_axi_bvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        guard(k == 100);
        `CHK(s_axi_bresp, er)
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 100 && s_axi_rvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        guard(k == 100);
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && busy_n !== 1'b1; k++) begin
            @(posedge aclk);
        end
        guard(k == 3000);
        repeat (8) @(posedge aclk);
    endtask
    task automatic conv(input logic [13:0] code, input logic bip, input logic again);
        @(posedge aclk);
        adc_code <= code;
        negative_supply <= bip;
        repeat (8) @(posedge aclk);
        host.start();
        `CHK(busy_n, 1'b0)
        if (again) begin
            adc_code <= ~code;
            repeat (10) @(posedge aclk);
            host.start();
        end
        wait_idle();
    endtask
    task automatic read_chk(input logic [5:0] n, input logic [15:0] word);
        host.read_word(n, 1'b0, w);
        want = {16'h0, word};
        want = n > 6'h10 ? want << (n - 6'h10) : want >> (6'h10 - n);
        `CHK(w, want)
    endtask
    initial begin
        {aresetn, negative_supply, ext_run, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ce, power_down_n} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, adc_code, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK({busy_n, conv_clock_output, nap, sleep, s_axi_bvalid, s_axi_rvalid}, 6'h20)
        axi_rd(REG_CONFIG, rd, resp);
        `CHK(rd, {24'h0, OSC_HALF_RESET})
        axi_rd(REG_COUNT, rd, resp);
        `CHK(rd, 32'h0)
        axi_wr(REG_CONFIG, 32'h3, RESP_OKAY);
        axi_wr(REG_STATUS, 32'h1F, RESP_OKAY);
        axi_wr(4'h6, 32'h0, RESP_SLVERR);
        axi_rd(REG_CONFIG, rd, resp);
        `CHK(rd, 32'h3)
        axi_rd(4'h2, rd, resp);
        `CHK({resp, rd}, {RESP_SLVERR, 32'h0})
        $display("test registers finished");
        for (int i = 0; i < 5; i++) begin
            conv(ROWS[i].code, ROWS[i].bip, 1'b0);
            read_chk(ROWS[i].n, ROWS[i].word);
        end
        axi_rd(REG_RESULT, rd, resp);
        `CHK(rd, 32'h8000)
        $display("test rows finished");
        conv(14'h1234, 1'b0, 1'b1);
        host.read_word(16, 1'b1, w);
        `CHK(dout_oe, 1'b0)
        read_chk(6'h10, 16'h48D0);
        $display("test restart and gating finished");
        ext_run <= 1'b1;
        conv(14'h0F0F, 1'b0, 1'b0);
        axi_rd(REG_STATUS, rd, resp);
        `CHK(rd[ST_EXT], 1'b1)
        read_chk(6'h10, 16'h3C3C);
        ext_run <= 1'b0;
        repeat (2100) @(posedge aclk);
        axi_rd(REG_STATUS, rd, resp);
        `CHK(rd[ST_EXT], 1'b0)
        $display("test clock selection finished");
        power_down_n <= 1'b0;
        repeat (10) @(posedge aclk);
        `CHK({nap, sleep}, 2'b10)
        host.start();
        `CHK(busy_n, 1'b1)
        host.read_word(0, 1'b1, w);
        repeat (10) @(posedge aclk);
        `CHK({nap, sleep}, 2'b01)
        power_down_n <= 1'b1;
        host.wake(1'b1);
        host.read_word(0, 1'b0, w);
        `CHK({nap, sleep}, 2'b00)
        host.start();
        repeat (20) @(posedge aclk);
        power_down_n <= 1'b0;
        repeat (10) @(posedge aclk);
        `CHK(busy_n, 1'b1)
        power_down_n <= 1'b1;
        host.wake(1'b0);
        conv(14'h3001, 1'b1, 1'b0);
        read_chk(6'h10, 16'h4004);
        axi_rd(REG_COUNT, rd, resp);
        `CHK(rd, 32'h8)
        $display("test power-down finished");
        conclude();
    end
endmodule
